// >>> core/dual_uart_baud_rate_control.sv
// Purpose: Baud-rate source selection and control for two UART channels
// Assumes: Registers reached over a plain 8-bit address/strobe port
// Notes: Rate ticks are one-cycle pulses to the UART engines
//
// Behaviour
// - Run bit 4 starts the channel generator when set, stops when clear
// - Transmit select bit 3 picks generator when set, else timer 1 or 2
// - Receive select bit 2 picks generator when set, independent of tx
// - Speed bit 1 picks fast generator when set, slow when clear
// - Mode 0 bit 0 picks generator; else clock by 12, or 6 double-speed
// - UART 1 control bit 7 doubles rate in modes 1, 2 and 3
// - UART 1 control bit 6 maps top mode bit onto framing error flag
// - Reserved bits read indeterminate; software writes no ones there
// - UART 0 control clears its five bits; UART 1 resets to zero
// - UART 0 control at 9Bh, UART 1 at BCh, not bit addressable
// - UART 0 double rate and framing select live in power control 7, 6
// - Timer path picks timer 2 overflow when set, else timer 1
// - Each generator reloads from its own 8-bit register, reset zero
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/100ps
module dual_uart_baud_rate_control
  import baud_ctl_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic double_speed_clock_mode,
  input wire logic timer1_overflow,
  input wire logic timer2_overflow,
  input wire logic [1:0] uart0_mode,
  input wire logic [1:0] uart1_mode,
  output chan_out_type uart0_out,
  output chan_out_type uart1_out
);
  logic [7:0] uart0_baud_control_ff;
  logic [7:0] uart1_baud_control_ff;
  logic [7:0] uart0_rate_reload_ff;
  logic [7:0] uart1_rate_reload_ff;
  logic [1:0] power_bits_ff;
  logic [1:0] timer_pick_ff;
  logic [7:0] nxt_rdata;
  chan_cfg_type cfg [2];
  logic [7:0] reload [2];
  logic [1:0] mode [2];
  logic [1:0] gen_tick;
  logic [1:0] tx_tick;
  logic [1:0] rx_tick;
  logic sync_tick;
  logic wr0;
  logic wr1;

  assign wr0 = reg_write && (reg_addr == UART0_BAUD_CONTROL_ADDR);
  assign wr1 = reg_write && (reg_addr == UART1_BAUD_CONTROL_ADDR);

  // Reserved bits are not stored, so ones written there have no effect
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      uart0_baud_control_ff <= BAUD_RESET;
    end else if (wr0) begin
      uart0_baud_control_ff <= reg_wdata & ~UART0_RSVD_MASK;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      uart1_baud_control_ff <= BAUD_RESET;
    end else if (wr1) begin
      uart1_baud_control_ff <= reg_wdata & ~UART1_RSVD_MASK;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      uart0_rate_reload_ff <= BAUD_RESET;
    end else if (reg_write && reg_addr == UART0_RATE_RELOAD_ADDR) begin
      uart0_rate_reload_ff <= reg_wdata;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      uart1_rate_reload_ff <= BAUD_RESET;
    end else if (reg_write && reg_addr == UART1_RATE_RELOAD_ADDR) begin
      uart1_rate_reload_ff <= reg_wdata;
    end
  end

  // Only the UART 0 serial bits of power control are held here
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      power_bits_ff <= 2'h0;
    end else if (reg_write && reg_addr == POWER_CONTROL_ADDR) begin
      power_bits_ff <= {reg_wdata[DOUBLE_BIT],
                        reg_wdata[FRAMING_SEL_BIT]};
    end
  end

  // Bit 1 is the receive pick, bit 0 the transmit pick
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      timer_pick_ff <= 2'h0;
    end else if (reg_write && reg_addr == TIMER2_CONTROL_ADDR) begin
      timer_pick_ff <= {reg_wdata[T2_RX_PICK_BIT],
                        reg_wdata[T2_TX_PICK_BIT]};
    end
  end

  always_comb begin
    cfg[0].double_rate = power_bits_ff[1];
    cfg[0].framing_flag_select = power_bits_ff[0];
    cfg[1].double_rate = uart1_baud_control_ff[DOUBLE_BIT];
    cfg[1].framing_flag_select = uart1_baud_control_ff[FRAMING_SEL_BIT];
    cfg[0].generator_run = uart0_baud_control_ff[RUN_BIT];
    cfg[1].generator_run = uart1_baud_control_ff[RUN_BIT];
    cfg[0].tx_rate_source = uart0_baud_control_ff[TX_SRC_BIT];
    cfg[1].tx_rate_source = uart1_baud_control_ff[TX_SRC_BIT];
    cfg[0].rx_rate_source = uart0_baud_control_ff[RX_SRC_BIT];
    cfg[1].rx_rate_source = uart1_baud_control_ff[RX_SRC_BIT];
    cfg[0].generator_speed = uart0_baud_control_ff[SPEED_BIT];
    cfg[1].generator_speed = uart1_baud_control_ff[SPEED_BIT];
    cfg[0].sync_rate_source = uart0_baud_control_ff[SYNC_SRC_BIT];
    cfg[1].sync_rate_source = uart1_baud_control_ff[SYNC_SRC_BIT];
    reload[0] = uart0_rate_reload_ff;
    reload[1] = uart1_rate_reload_ff;
    mode[0] = uart0_mode;
    mode[1] = uart1_mode;
  end

  sync_divider u_sync_div (
    .clock(clock),
    .rst_n(rst_n),
    .double_speed(double_speed_clock_mode),
    .tick(sync_tick)
  );

  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    logic timer_tx;
    logic timer_rx;
    logic tx_ff;
    logic rx_ff;

    rate_generator u_gen (
      .clock(clock),
      .rst_n(rst_n),
      .run(cfg[ch].generator_run),
      .fast(cfg[ch].generator_speed),
      .reload(reload[ch]),
      .tick(gen_tick[ch])
    );

    assign timer_tx = timer_pick_ff[0] ? timer2_overflow
                                       : timer1_overflow;
    assign timer_rx = timer_pick_ff[1] ? timer2_overflow
                                       : timer1_overflow;

    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        tx_ff <= 1'b0;
      end else if (mode[ch] == MODE_SYNC) begin
        tx_ff <= cfg[ch].sync_rate_source ? gen_tick[ch] : sync_tick;
      end else begin
        tx_ff <= cfg[ch].tx_rate_source ? gen_tick[ch] : timer_tx;
      end
    end

    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        rx_ff <= 1'b0;
      end else if (mode[ch] == MODE_SYNC) begin
        rx_ff <= cfg[ch].sync_rate_source ? gen_tick[ch] : sync_tick;
      end else begin
        rx_ff <= cfg[ch].rx_rate_source ? gen_tick[ch] : timer_rx;
      end
    end

    assign tx_tick[ch] = tx_ff;
    assign rx_tick[ch] = rx_ff;
  end

  always_comb begin
    uart0_out.tx_tick = tx_tick[0];
    uart0_out.rx_tick = rx_tick[0];
    uart0_out.double_rate = cfg[0].double_rate;
    uart0_out.framing_flag_select = cfg[0].framing_flag_select;
    uart1_out.tx_tick = tx_tick[1];
    uart1_out.rx_tick = rx_tick[1];
    uart1_out.double_rate = cfg[1].double_rate;
    uart1_out.framing_flag_select = cfg[1].framing_flag_select;
  end

  // Reserved bits read as the fill value; unmapped addresses read zero
  always_comb begin
    nxt_rdata = 8'h00;
    unique case (reg_addr)
      UART0_BAUD_CONTROL_ADDR:
        nxt_rdata = uart0_baud_control_ff | RSVD_READ_FILL;
      UART1_BAUD_CONTROL_ADDR:
        nxt_rdata = uart1_baud_control_ff | RSVD_READ_FILL;
      UART0_RATE_RELOAD_ADDR: nxt_rdata = uart0_rate_reload_ff;
      UART1_RATE_RELOAD_ADDR: nxt_rdata = uart1_rate_reload_ff;
      default: nxt_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      reg_rdata <= nxt_rdata;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Register port checks
  rsvd_zero_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    (uart0_baud_control_ff & UART0_RSVD_MASK) == 8'h00 &&
    (uart1_baud_control_ff & UART1_RSVD_MASK) == 8'h00)
    else $error("reserved control bit stored");

  ctl_write_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    wr0 |=> uart0_baud_control_ff == ($past(reg_wdata) & ~UART0_RSVD_MASK))
    else $error("uart0 control write not taken");

  readback_ctl_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    wr1 ##1 reg_read && reg_addr == UART1_BAUD_CONTROL_ADDR && !reg_write
    |=> reg_rdata == ($past(reg_wdata, 2) & ~UART1_RSVD_MASK))
    else $error("uart1 control readback mismatch");

  ctl_read_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    reg_read && reg_addr == UART0_BAUD_CONTROL_ADDR
    |=> reg_rdata == $past(uart0_baud_control_ff))
    else $error("uart0 control readback mismatch");

  reload_read_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    reg_read && reg_addr == UART0_RATE_RELOAD_ADDR
    |=> reg_rdata == $past(uart0_rate_reload_ff))
    else $error("uart0 reload readback mismatch");

  // Read data stands for one cycle only
  rdata_idle_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    !reg_read |=> reg_rdata == 8'h00)
    else $error("read data held without a read");

  power_map_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    reg_write && reg_addr == POWER_CONTROL_ADDR
    |=> uart0_out.double_rate == $past(reg_wdata[DOUBLE_BIT]) &&
    uart0_out.framing_flag_select == $past(reg_wdata[FRAMING_SEL_BIT]))
    else $error("uart0 mode bits not taken");

  timer_pick_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    reg_write && reg_addr == TIMER2_CONTROL_ADDR
    |=> timer_pick_ff[1] == $past(reg_wdata[T2_RX_PICK_BIT]) &&
    timer_pick_ff[0] == $past(reg_wdata[T2_TX_PICK_BIT]))
    else $error("timer pick bits not taken");

  double_map_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    wr1 |=> uart1_out.double_rate == $past(reg_wdata[DOUBLE_BIT]) &&
    uart1_out.framing_flag_select == $past(reg_wdata[FRAMING_SEL_BIT]))
    else $error("uart1 mode bits not taken");

  // Rate path checks: each path tick is its source delayed by one cycle; a stopped generator gives no tick
  tx_gen_path_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    uart0_mode != MODE_SYNC && cfg[0].tx_rate_source
    |=> tx_tick[0] == $past(gen_tick[0]))
    else $error("uart0 tx not fed by generator");

  rx_gen_path_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    uart1_mode != MODE_SYNC && cfg[1].rx_rate_source
    |=> rx_tick[1] == $past(gen_tick[1]))
    else $error("uart1 rx not fed by generator");

  rx_timer_path_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    uart1_mode != MODE_SYNC && !cfg[1].rx_rate_source && timer_pick_ff[1]
    |=> rx_tick[1] == $past(timer2_overflow))
    else $error("uart1 rx not fed by timer 2");

  tx_timer1_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    uart0_mode != MODE_SYNC && !cfg[0].tx_rate_source && !timer_pick_ff[0]
    |=> tx_tick[0] == $past(timer1_overflow))
    else $error("uart0 tx not fed by timer 1");

  tx_timer2_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    uart1_mode != MODE_SYNC && !cfg[1].tx_rate_source && timer_pick_ff[0]
    |=> tx_tick[1] == $past(timer2_overflow))
    else $error("uart1 tx not fed by timer 2");

  rx_timer1_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    uart0_mode != MODE_SYNC && !cfg[0].rx_rate_source && !timer_pick_ff[1]
    |=> rx_tick[0] == $past(timer1_overflow))
    else $error("uart0 rx not fed by timer 1");

  sync_path_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    uart0_mode == MODE_SYNC && !cfg[0].sync_rate_source
    |=> rx_tick[0] == $past(sync_tick))
    else $error("mode 0 not fed by fixed divider");

  sync_fixed_tx_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    uart1_mode == MODE_SYNC && !cfg[1].sync_rate_source
    |=> tx_tick[1] == $past(sync_tick))
    else $error("uart1 mode 0 tx not fed by fixed divider");

  sync_gen_path_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    uart0_mode == MODE_SYNC && cfg[0].sync_rate_source
    |=> tx_tick[0] == $past(gen_tick[0]))
    else $error("uart0 mode 0 tx not fed by generator");

  stopped_silent_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    !cfg[1].generator_run [*3] |-> !gen_tick[1])
    else $error("stopped generator produced tick");

  gen_tick_c: cover property (@(posedge clock) disable iff (!rst_n)
    cfg[0].generator_run && cfg[0].generator_speed ##1 gen_tick[0]);
  slow_tick_c: cover property (@(posedge clock) disable iff (!rst_n)
    !cfg[1].generator_speed && gen_tick[1]);
  sync_tick_c: cover property (@(posedge clock) disable iff (!rst_n)
    uart1_mode == MODE_SYNC && tx_tick[1]);
  rx_timer_c: cover property (@(posedge clock) disable iff (!rst_n)
    uart0_mode != MODE_SYNC && !cfg[0].rx_rate_source && rx_tick[0]);
  x2_sync_c: cover property (@(posedge clock) disable iff (!rst_n)
    double_speed_clock_mode && uart1_mode == MODE_SYNC && rx_tick[1]);
endmodule // dual_uart_baud_rate_control

// >>> core/baud_ctl_pkg.sv
// Purpose: Constants and carriers for the dual UART baud-rate control
// Assumes: 8-bit special-function register port, 25 MHz peripheral clock
// Notes: Offsets are the special-function addresses
package baud_ctl_pkg;
  localparam logic [7:0] UART0_BAUD_CONTROL_ADDR = 8'h9B;
  localparam logic [7:0] UART1_BAUD_CONTROL_ADDR = 8'hBC;
  localparam logic [7:0] UART0_RATE_RELOAD_ADDR = 8'h9A;
  localparam logic [7:0] UART1_RATE_RELOAD_ADDR = 8'hBB;
  localparam logic [7:0] POWER_CONTROL_ADDR = 8'h87;
  localparam logic [7:0] TIMER2_CONTROL_ADDR = 8'hC8;
  localparam logic [7:0] BAUD_RESET = 8'h00;
  localparam logic [7:0] UART0_RSVD_MASK = 8'hE0;
  localparam logic [7:0] UART1_RSVD_MASK = 8'h20;
  localparam logic [7:0] RSVD_READ_FILL = 8'h00;
  localparam int RUN_BIT = 4;
  localparam int TX_SRC_BIT = 3;
  localparam int RX_SRC_BIT = 2;
  localparam int SPEED_BIT = 1;
  localparam int SYNC_SRC_BIT = 0;
  localparam int DOUBLE_BIT = 7;
  localparam int FRAMING_SEL_BIT = 6;
  localparam int T2_RX_PICK_BIT = 5;
  localparam int T2_TX_PICK_BIT = 4;
  localparam logic [3:0] SLOW_PRESCALE = 4'h5;
  localparam logic [3:0] FAST_PRESCALE = 4'h0;
  localparam logic [3:0] SYNC_DIV_STD = 4'hB;
  localparam logic [3:0] SYNC_DIV_X2 = 4'h5;
  localparam logic [1:0] MODE_SYNC = 2'h0;

  typedef struct packed {
    logic double_rate;
    logic framing_flag_select;
    logic generator_run;
    logic tx_rate_source;
    logic rx_rate_source;
    logic generator_speed;
    logic sync_rate_source;
  } chan_cfg_type;

  typedef struct packed {
    logic tx_tick;
    logic rx_tick;
    logic double_rate;
    logic framing_flag_select;
  } chan_out_type;
endpackage

// >>> core/rate_generator.sv
// Purpose: Internal baud-rate generator, 8-bit reload counter with prescale
// Assumes: Reload value and controls come from registers on the same clock
// Notes: One tick per counter overflow after the selected prescale
`timescale 1ns/100ps
module rate_generator
  import baud_ctl_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic run,
  input wire logic fast,
  input wire logic [7:0] reload,
  output logic tick
);
  logic [7:0] count_ff;
  logic [3:0] pre_ff;
  logic pre_done;
  logic [3:0] pre_limit;

  assign pre_limit = fast ? FAST_PRESCALE : SLOW_PRESCALE;
  assign pre_done = (pre_ff == pre_limit);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pre_ff <= 4'h0;
    end else if (!run || pre_done) begin
      pre_ff <= 4'h0;
    end else begin
      pre_ff <= pre_ff + 4'h1;
    end
  end

  // Stopped generator holds the reload so a restart begins a full period
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count_ff <= 8'h00;
    end else if (!run) begin
      count_ff <= reload;
    end else if (pre_done) begin
      count_ff <= (count_ff == 8'hFF) ? reload : count_ff + 8'h01;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tick <= 1'b0;
    end else begin
      tick <= run && pre_done && (count_ff == 8'hFF);
    end
  end

  stopped_quiet_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    !run |=> !tick)
    else $error("generator ticked while stopped");
endmodule // rate_generator

// >>> core/sync_divider.sv
// Purpose: Fixed mode-0 clock divider, by 12 or by 6 in double-speed mode
// Assumes: clock is the oscillator/peripheral clock
// Notes: Output is a one-cycle tick
`timescale 1ns/100ps
module sync_divider
  import baud_ctl_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic double_speed,
  output logic tick
);
  logic [3:0] div_ff;
  logic [3:0] limit;

  assign limit = double_speed ? SYNC_DIV_X2 : SYNC_DIV_STD;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      div_ff <= 4'h0;
    end else if (div_ff >= limit) begin
      div_ff <= 4'h0;
    end else begin
      div_ff <= div_ff + 4'h1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tick <= 1'b0;
    end else begin
      tick <= (div_ff >= limit);
    end
  end
endmodule // sync_divider

// >>> bench/uart_engine_model.sv
// Purpose: Far-side model of one channel's UART engines, counting rate ticks
// Assumes: Ticks are one-cycle pulses on the shared clock
// Notes: Counts only, no shifting; the bench reads the totals
`timescale 1ns/100ps
module uart_engine_model
  import baud_ctl_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire chan_out_type chan,
  output logic [15:0] tx_ticks_ff,
  output logic [15:0] rx_ticks_ff
);
  // Each engine counts one step per tick it is given
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tx_ticks_ff <= 16'h0000;
    end else if (chan.tx_tick) begin
      tx_ticks_ff <= tx_ticks_ff + 16'h0001;
    end
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rx_ticks_ff <= 16'h0000;
    end else if (chan.rx_tick) begin
      rx_ticks_ff <= rx_ticks_ff + 16'h0001;
    end
  end
endmodule // uart_engine_model

// >>> bench/dual_uart_baud_rate_control_tb.sv
// Purpose: Self-checking bench for the dual UART baud-rate control
// Assumes: Register port answers reads one cycle later
// Notes: Tick counts allow one tick of slack at window edges
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin \
  mismatches++; $display("[FAIL] %s expected %0h seen %0h", nm, exp, got); \
  end end
module dual_uart_baud_rate_control_tb
  import baud_ctl_pkg::*;
;
  logic clock, rst_n, reg_write, reg_read, x2, t1, t2;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rv, r0;
  logic [1:0] m0, m1;
  chan_out_type u0, u1;
  logic [15:0] tx0, rx0, tx1, rx1;
  logic [15:0] s [4];
  int mismatches, checks, cycles;

  dual_uart_baud_rate_control dut (.clock(clock), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata),
    .double_speed_clock_mode(x2), .timer1_overflow(t1),
    .timer2_overflow(t2), .uart0_mode(m0), .uart1_mode(m1),
    .uart0_out(u0), .uart1_out(u1));
  uart_engine_model eng0 (.clock(clock), .rst_n(rst_n), .chan(u0),
    .tx_ticks_ff(tx0), .rx_ticks_ff(rx0));
  uart_engine_model eng1 (.clock(clock), .rst_n(rst_n), .chan(u1),
    .tx_ticks_ff(tx1), .rx_ticks_ff(rx1));

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e,
                        input string nm);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    `CHK(nm, e, reg_rdata)
  endtask
  task automatic pulse(input bit two);
    @(posedge clock);
    if (two) t2 <= 1'b1;
    else t1 <= 1'b1;
    @(posedge clock);
    t1 <= 1'b0;
    t2 <= 1'b0;
  endtask
  // Write then read back with no gap between the strobes
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d,
                       input logic [7:0] e, input string nm);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    `CHK(nm, e, reg_rdata)
  endtask
  function automatic logic near(input int e, input logic [15:0] g,
                                input bit ex);
    int v;
    v = int'(g);
    if ($isunknown(g)) return 1'b0;
    return ex ? (v == e) : (v >= e - 1 && v <= e + 1);
  endfunction
  task automatic snap;
    s[0] = tx0;
    s[1] = rx0;
    s[2] = tx1;
    s[3] = rx1;
  endtask
  task automatic cmp(input int a, input int b, input int c, input int d,
                     input bit ex);
    #1;
    `CHK("uart0 tx ticks", 1'b1, near(a, tx0 - s[0], ex))
    `CHK("uart0 rx ticks", 1'b1, near(b, rx0 - s[1], ex))
    `CHK("uart1 tx ticks", 1'b1, near(c, tx1 - s[2], ex))
    `CHK("uart1 rx ticks", 1'b1, near(d, rx1 - s[3], ex))
  endtask

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      complete_run();
    end
  end
  initial begin
    rst_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
    {x2, t1, t2} = 3'h0;
    m0 = 2'h1;
    m1 = 2'h1;
    void'($urandom(66697));
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    rd_chk(UART0_BAUD_CONTROL_ADDR, BAUD_RESET, "ctl0 reset");
    rd_chk(UART1_BAUD_CONTROL_ADDR, BAUD_RESET, "ctl1 reset");
    rd_chk(UART0_RATE_RELOAD_ADDR, 8'h00, "reload0 reset");
    rd_chk(UART1_RATE_RELOAD_ADDR, 8'h00, "reload1 reset");
    $display("test reset values done");
    wr(UART0_BAUD_CONTROL_ADDR, 8'h1F);
    rd_chk(UART0_BAUD_CONTROL_ADDR, 8'h1F, "ctl0 reserved");
    wr(UART1_BAUD_CONTROL_ADDR, 8'hDF);
    rd_chk(UART1_BAUD_CONTROL_ADDR, 8'hDF, "ctl1 reserved");
    `CHK("uart1 double", 1'b1, u1.double_rate)
    `CHK("uart1 frame sel", 1'b1, u1.framing_flag_select)
    rd_chk(8'h55, 8'h00, "unmapped read");
    for (int i = 0; i < 8; i++) begin
      rv = 8'($urandom);
      wr(UART0_BAUD_CONTROL_ADDR, rv & ~UART0_RSVD_MASK);
      wr_rd(UART1_BAUD_CONTROL_ADDR, rv & 8'hDF, rv & 8'hDF,
            "ctl1 rw");
      rd_chk(UART0_BAUD_CONTROL_ADDR, rv & 8'h1F, "ctl0 rw");
      #1;
      `CHK("uart1 double rw", rv[7], u1.double_rate)
    end
    wr(POWER_CONTROL_ADDR, 8'hC0);
    #1;
    `CHK("uart0 double", 1'b1, u0.double_rate)
    `CHK("uart0 frame sel", 1'b1, u0.framing_flag_select)
    wr(POWER_CONTROL_ADDR, 8'h00);
    $display("test registers done");
    rv = 8'($urandom);
    m0 <= {rv[0], 1'b1};
    m1 <= {rv[1], 1'b1};
    wr(UART0_BAUD_CONTROL_ADDR, 8'h00);
    wr(UART1_BAUD_CONTROL_ADDR, 8'h00);
    for (int p = 0; p < 4; p++) begin
      wr(TIMER2_CONTROL_ADDR, 8'(p << 4));
      snap();
      repeat (3) pulse(1'b0);
      pulse(1'b1);
      repeat (3) @(posedge clock);
      cmp(p[0] ? 1 : 3, p[1] ? 1 : 3, p[0] ? 1 : 3, p[1] ? 1 : 3, 1);
    end
    $display("test timer sources done");
    r0 = 8'hF0 + 8'($urandom % 13);
    wr(UART0_RATE_RELOAD_ADDR, r0);
    wr(UART1_RATE_RELOAD_ADDR, 8'hFA);
    rd_chk(UART0_RATE_RELOAD_ADDR, r0, "reload0 rw");
    wr(UART0_BAUD_CONTROL_ADDR, 8'h1E);
    wr(UART1_BAUD_CONTROL_ADDR, 8'h1C);
    snap();
    repeat (360) @(posedge clock);
    cmp(360 / (256 - r0), 360 / (256 - r0), 10, 10, 0);
    wr(UART0_BAUD_CONTROL_ADDR, 8'h0E);
    wr(UART1_BAUD_CONTROL_ADDR, 8'h0C);
    // Let a tick launched at the stopping edge reach the counters first
    repeat (2) @(posedge clock);
    snap();
    repeat (100) @(posedge clock);
    cmp(0, 0, 0, 0, 1);
    wr(UART0_RATE_RELOAD_ADDR, 8'hFC);
    wr(UART1_RATE_RELOAD_ADDR, 8'hFC);
    wr(UART0_BAUD_CONTROL_ADDR, 8'h1A);
    wr(UART1_BAUD_CONTROL_ADDR, 8'h16);
    snap();
    repeat (80) @(posedge clock);
    cmp(20, 0, 0, 20, 0);
    $display("test generator done");
    @(posedge clock);
    m0 <= 2'h0;
    m1 <= 2'h0;
    wr(UART0_BAUD_CONTROL_ADDR, 8'h00);
    wr(UART1_BAUD_CONTROL_ADDR, 8'h00);
    snap();
    repeat (240) @(posedge clock);
    cmp(20, 20, 20, 20, 0);
    @(posedge clock);
    x2 <= 1'b1;
    wr(UART0_BAUD_CONTROL_ADDR, 8'h13);
    snap();
    repeat (240) @(posedge clock);
    cmp(60, 60, 40, 40, 0);
    $display("test mode 0 done");
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    rd_chk(UART0_BAUD_CONTROL_ADDR, BAUD_RESET, "ctl0 rerun");
    rd_chk(UART0_RATE_RELOAD_ADDR, 8'h00, "reload0 rerun");
    $display("test mid-run reset done");
    complete_run();
  end
endmodule // dual_uart_baud_rate_control_tb
